/* rtl/ccu_pkg.sv */
/*
 Package for the compare condition unit: opcodes, condition codes,
 real-number field layouts and the operation request / result carriers.
 Assumes a single 25 MHz core clock shared by all users.
*/
`default_nettype none
package ccu_pkg;
   // Condition code encodings
   localparam logic [2:0] CCU_CC_LESS = 3'h4;
   localparam logic [2:0] CCU_CC_EQUAL = 3'h2;
   localparam logic [2:0] CCU_CC_GREATER = 3'h1;
   localparam logic [2:0] CCU_CC_UNORD = 3'h0;
   // Instruction opcodes (register format)
   localparam logic [11:0] CCU_OP_CMPINCO = 12'h5A4;
   localparam logic [11:0] CCU_OP_CMPINCI = 12'h5A5;
   localparam logic [11:0] CCU_OP_CMPDECO = 12'h5A6;
   localparam logic [11:0] CCU_OP_CMPDECI = 12'h5A7;
   localparam logic [11:0] CCU_OP_CMPOR = 12'h684;
   localparam logic [11:0] CCU_OP_CMPR = 12'h685;
   localparam logic [11:0] CCU_OP_CMPORL = 12'h694;
   localparam logic [11:0] CCU_OP_CMPRL = 12'h695;
   localparam logic [11:0] CCU_OP_CMPSTR = 12'h603;
   // Single real layout
   localparam int CCU_R_SIGN = 31;
   localparam int CCU_R_EXP_HI = 30;
   localparam int CCU_R_EXP_LO = 23;
   localparam int CCU_R_QUIET = 22;
   localparam int CCU_R_MAN_HI = 22;
   // Long real layout
   localparam int CCU_L_SIGN = 63;
   localparam int CCU_L_EXP_HI = 62;
   localparam int CCU_L_EXP_LO = 52;
   localparam int CCU_L_QUIET = 51;
   localparam int CCU_L_MAN_HI = 51;
   localparam logic [0:0] CCU_ONE = 1'h1;

   // Operation request from the decoder
   typedef struct packed {
      logic [11:0] opcode;
      logic [63:0] src1;
      logic [63:0] src2;
      logic [31:0] len;
   } ccu_req_s;

   // Result towards register file and arithmetic controls
   typedef struct packed {
      logic [2:0] cc;
      logic cc_undef;
      logic dst_we;
      logic [31:0] dst;
      logic invalid_op;
      logic reserved_enc;
      logic fault;
   } ccu_res_s;

   // Floating mask and mode bits from the arithmetic controls
   typedef struct packed {
      logic norm_mode;
      logic invalid_mask;
      logic resenc_mask;
   } ccu_ctl_s;
endpackage : ccu_pkg
`default_nettype wire

/* rtl/ccu_unit.sv */
/*
 Compare condition unit: integer/ordinal compare-and-increment and
 decrement, ordered and unordered real and long-real compares, and
 byte-string compare with a memory read port fetching one byte pair per read, at most one read every two cycles.
 Assumes the decoder holds the request until done_o, and memory answers
 every read with rd_valid_i in some later cycle.
*/
`default_nettype none
module ccu_unit
   import ccu_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire ccu_req_s req_i,
   input wire ccu_ctl_s ctl_i,
   output logic busy_o,
   output logic done_o,
   output ccu_res_s res_o,
   output logic rd_req_o,
   output logic [31:0] rd_addr1_o,
   output logic [31:0] rd_addr2_o,
   input wire logic rd_valid_i,
   input wire logic [7:0] rd_byte1_i,
   input wire logic [7:0] rd_byte2_i
);

   ////////////////////////////////////////////////////////////////////
   // State machine
   typedef enum logic [2:0] {
      CCU_IDLE = 3'b001,
      CCU_SREQ = 3'b010,
      CCU_SWAIT = 3'b100
   } ccu_state_e;

   ccu_state_e state;
   logic [31:0] str_left;
   logic [31:0] str_off;
   logic [31:0] base1;
   logic [31:0] base2;
   ccu_res_s next_res;
   logic is_str;

   // Integer compare helpers
   function automatic logic [2:0] ccu_cmp3(input logic lt, input logic eq);
      if (lt) begin
         ccu_cmp3 = CCU_CC_LESS;
      end else if (eq) begin
         ccu_cmp3 = CCU_CC_EQUAL;
      end else begin
         ccu_cmp3 = CCU_CC_GREATER;
      end
   endfunction : ccu_cmp3

   ////////////////////////////////////////////////////////////////////
   // Real operand classification
   logic is_long;
   logic [1:0] nan_any;
   logic [1:0] nan_sig;
   logic [1:0] denorm;
   logic [1:0] zero;
   logic [1:0] sgn;
   logic [62:0] mag [2];

   assign is_long = (req_i.opcode == CCU_OP_CMPORL) || (req_i.opcode == CCU_OP_CMPRL);

   // Per-operand classification
   for (genvar g = 0; g < 2; g++) begin : g_cls
      logic [63:0] v;
      logic exp_ones;
      logic exp_zero;
      logic man_nz;
      logic quiet;
      assign v = (g == 0) ? req_i.src1 : req_i.src2;
      assign exp_ones = is_long ? (&v[CCU_L_EXP_HI:CCU_L_EXP_LO])
                                : (&v[CCU_R_EXP_HI:CCU_R_EXP_LO]);
      assign exp_zero = is_long ? ~(|v[CCU_L_EXP_HI:CCU_L_EXP_LO])
                                : ~(|v[CCU_R_EXP_HI:CCU_R_EXP_LO]);
      assign man_nz = is_long ? (|v[CCU_L_MAN_HI:0]) : (|v[CCU_R_MAN_HI:0]);
      assign quiet = is_long ? v[CCU_L_QUIET] : v[CCU_R_QUIET];
      assign nan_any[g] = exp_ones & man_nz;
      assign nan_sig[g] = exp_ones & man_nz & ~quiet;
      assign denorm[g] = exp_zero & man_nz;
      assign zero[g] = exp_zero & ~man_nz;
      assign sgn[g] = is_long ? v[CCU_L_SIGN] : v[CCU_R_SIGN];
      assign mag[g] = is_long ? v[CCU_L_EXP_HI:0] : {32'h0, v[CCU_R_EXP_HI:0]};
   end

   // Real ordering from sign and magnitude
   logic r_eq;
   logic r_lt;
   always_comb begin
      r_eq = (zero[0] && zero[1]) || (sgn[0] == sgn[1] && mag[0] == mag[1]);
      // Plus and minus zero are equal, never less
      if (sgn[0] != sgn[1]) begin
         r_lt = sgn[0] && !r_eq;
      end else begin
         r_lt = sgn[0] ? (mag[0] > mag[1]) : (mag[0] < mag[1]);
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Single-cycle result for non-string operations
   logic ordered;
   logic [31:0] a32;
   logic [31:0] b32;
   always_comb begin
      a32 = req_i.src1[31:0];
      b32 = req_i.src2[31:0];
      ordered = (req_i.opcode == CCU_OP_CMPOR) || (req_i.opcode == CCU_OP_CMPORL);
      is_str = (req_i.opcode == CCU_OP_CMPSTR);
      next_res = '0;
      unique case (req_i.opcode)
         CCU_OP_CMPINCI, CCU_OP_CMPDECI: begin
            next_res.cc = ccu_cmp3($signed(a32) < $signed(b32), a32 == b32);
         end
         CCU_OP_CMPINCO, CCU_OP_CMPDECO: begin
            next_res.cc = ccu_cmp3(a32 < b32, a32 == b32);
         end
         CCU_OP_CMPOR, CCU_OP_CMPR, CCU_OP_CMPORL, CCU_OP_CMPRL: begin
            if (|nan_any) begin
               next_res.cc = CCU_CC_UNORD;
               next_res.invalid_op = ordered ? 1'b1 : (|nan_sig);
            end else begin
               next_res.cc = ccu_cmp3(r_lt, r_eq);
            end
            next_res.reserved_enc = ctl_i.norm_mode & (|denorm);
            next_res.cc_undef = next_res.reserved_enc;
         end
         default: begin
            next_res.cc = CCU_CC_EQUAL;
         end
      endcase
      // Destination write, wrapping without overflow fault
      if (req_i.opcode == CCU_OP_CMPINCI || req_i.opcode == CCU_OP_CMPINCO) begin
         next_res.dst_we = 1'b1;
         next_res.dst = b32 + 32'(CCU_ONE);
      end else if (req_i.opcode == CCU_OP_CMPDECI || req_i.opcode == CCU_OP_CMPDECO) begin
         next_res.dst_we = 1'b1;
         next_res.dst = b32 - 32'(CCU_ONE);
      end
      // Masked exceptions do not fault
      next_res.fault = (next_res.invalid_op & ~ctl_i.invalid_mask)
                     | (next_res.reserved_enc & ~ctl_i.resenc_mask);
   end

   ////////////////////////////////////////////////////////////////////
   // Sequencer and result register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= CCU_IDLE;
         done_o <= 1'b0;
         res_o <= '0;
         str_left <= '0;
         str_off <= '0;
         base1 <= '0;
         base2 <= '0;
      end else begin
         done_o <= 1'b0;
         unique case (state)
            CCU_IDLE: begin
               if (start_i && is_str) begin
                  res_o <= next_res;
                  str_left <= req_i.len;
                  str_off <= '0;
                  base1 <= req_i.src1[31:0];
                  base2 <= req_i.src2[31:0];
                  if (req_i.len == 32'h0) begin
                     done_o <= 1'b1;
                  end else begin
                     state <= CCU_SREQ;
                  end
               end else if (start_i) begin
                  res_o <= next_res;
                  done_o <= 1'b1;
               end
            end
            CCU_SREQ: begin
               state <= CCU_SWAIT;
            end
            CCU_SWAIT: begin
               if (rd_valid_i) begin
                  if (rd_byte1_i > rd_byte2_i) begin
                     res_o.cc <= CCU_CC_GREATER;
                     done_o <= 1'b1;
                     state <= CCU_IDLE;
                  end else if (rd_byte1_i < rd_byte2_i) begin
                     res_o.cc <= CCU_CC_LESS;
                     done_o <= 1'b1;
                     state <= CCU_IDLE;
                  end else if (str_left == 32'h1) begin
                     done_o <= 1'b1;
                     state <= CCU_IDLE;
                  end else begin
                     str_left <= str_left - 32'(CCU_ONE);
                     str_off <= str_off + 32'(CCU_ONE);
                     state <= CCU_SREQ;
                  end
               end
            end
         endcase
      end
   end

   // Memory read port and busy flag
   assign rd_req_o = (state == CCU_SREQ);
   assign rd_addr1_o = base1 + str_off;
   assign rd_addr2_o = base2 + str_off;
   assign busy_o = (state != CCU_IDLE);

   ////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // Integer compare and step
   chk_inc_dst: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPINCO |=> done_o && res_o.dst == $past(req_i.src2[31:0]) + 32'h1)
      else $error("increment result wrong");
   chk_dec_dst: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPDECI |=> res_o.dst == $past(req_i.src2[31:0]) - 32'h1)
      else $error("decrement result wrong");
   chk_dec_cc: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPDECO
      && req_i.src1[31:0] < req_i.src2[31:0] |=> res_o.cc == CCU_CC_LESS)
      else $error("decrement compare code wrong");
   chk_int_cc: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPINCI
      && $signed(req_i.src1[31:0]) < $signed(req_i.src2[31:0]) |=> res_o.cc == CCU_CC_LESS)
      else $error("signed less code wrong");
   chk_ord_cc: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPINCO
      && req_i.src1[31:0] > req_i.src2[31:0] |=> res_o.cc == CCU_CC_GREATER)
      else $error("unsigned greater code wrong");
   chk_nowrap_flt: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPINCI |=> !res_o.fault && !res_o.invalid_op)
      else $error("increment raised a fault");
   // Real compare
   chk_ordnan_inv: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPOR
      && |nan_any |=> res_o.cc == CCU_CC_UNORD && res_o.invalid_op)
      else $error("ordered NaN handling wrong");
   chk_long_nan: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPORL
      && |nan_any |=> res_o.cc == CCU_CC_UNORD && res_o.invalid_op)
      else $error("ordered long NaN handling wrong");
   chk_qnan_quiet: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPR && |nan_any && !(|nan_sig)
      |=> res_o.cc == CCU_CC_UNORD && !res_o.invalid_op)
      else $error("quiet NaN raised invalid");
   chk_snan_inv: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPRL
      && |nan_sig |=> res_o.cc == CCU_CC_UNORD && res_o.invalid_op)
      else $error("signaling NaN missed invalid");
   chk_zero_eq: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPOR && &zero |=> res_o.cc == CCU_CC_EQUAL)
      else $error("signed zeros not equal");
   chk_resenc_flag: assert property (start_i && !busy_o
      && req_i.opcode == CCU_OP_CMPRL && ctl_i.norm_mode && |denorm
      |=> res_o.reserved_enc && res_o.cc_undef)
      else $error("reserved encoding missed");
   chk_mask_flt: assert property (done_o |-> res_o.fault == ((res_o.invalid_op
      && !$past(ctl_i.invalid_mask)) || (res_o.reserved_enc && !$past(ctl_i.resenc_mask))))
      else $error("fault masking wrong");
   // String compare
   chk_str_start: assert property (start_i && !busy_o && is_str
      && req_i.len != 32'h0 |=> busy_o && rd_req_o && !done_o)
      else $error("string compare did not start");
   chk_str_equal: assert property (state == CCU_SWAIT && rd_valid_i
      && rd_byte1_i == rd_byte2_i && str_left == 32'h1 |=> done_o && res_o.cc == CCU_CC_EQUAL)
      else $error("equal string code wrong");
   chk_str_stop: assert property (state == CCU_SWAIT && rd_valid_i
      && rd_byte1_i != rd_byte2_i |=> done_o && !busy_o)
      else $error("string did not stop at mismatch");
   chk_str_zero: assert property (start_i && !busy_o
      && is_str && req_i.len == 32'h0
      |=> done_o && res_o.cc == CCU_CC_EQUAL)
      else $error("zero length string wrong");

   // Coverage of the main scenarios
   cov_str_mis: cover property (state == CCU_SWAIT && rd_valid_i && rd_byte1_i < rd_byte2_i);
   cov_str_eq: cover property (done_o && res_o.cc == CCU_CC_EQUAL && $past(state == CCU_SWAIT));
   cov_snan: cover property (start_i && req_i.opcode == CCU_OP_CMPR && |nan_sig);
   cov_szero: cover property (start_i && req_i.opcode == CCU_OP_CMPOR && &zero);
   cov_wrap: cover property (start_i && req_i.opcode == CCU_OP_CMPINCI
      && req_i.src2[31:0] == 32'h7FFFFFFF);
endmodule : ccu_unit
`default_nettype wire

/* tb/ccu_mem_model.sv */
/*
 Byte memory behind the compare unit's string read port.
 Assumes one read in flight; answers one or three cycles late.
*/
`default_nettype none
module ccu_mem_model (
   input wire logic clk_i,
   input wire logic slow_i,
   input wire logic req_i,
   input wire logic [31:0] addr1_i,
   input wire logic [31:0] addr2_i,
   output logic valid_o,
   output logic [7:0] byte1_o,
   output logic [7:0] byte2_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem1 [256];
   logic [7:0] mem2 [256];
   logic [7:0] a1;
   logic [7:0] a2;
   ////////////////////////////////////////////////////////////////
   // Answer each pair, then scramble stale data lines
   initial begin
      valid_o = 1'b0;
      byte1_o = 8'h00;
      byte2_o = 8'h00;
      forever begin
         @(negedge clk_i);
         if (req_i === 1'b1) begin
            a1 = addr1_i[7:0];
            a2 = addr2_i[7:0];
            repeat (slow_i ? 3 : 1) @(posedge clk_i);
            #1;
            valid_o = 1'b1;
            byte1_o = mem1[a1];
            byte2_o = mem2[a2];
            @(posedge clk_i);
            #1;
            valid_o = 1'b0;
            byte1_o = ~byte1_o;
            byte2_o = ~byte2_o;
         end
      end
   end
endmodule : ccu_mem_model
`default_nettype wire

/* tb/tb_top.sv */
/*
 Self-checking bench for the compare unit: random integer, real and
 string compares plus corners. Assumes the unit answers per its note.
*/
`default_nettype none
module tb_top import ccu_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, start, busy, done, rd_req, rd_valid, slow;
   logic [31:0] a1, a2;
   logic [7:0] b1, b2;
   ccu_req_s req;
   ccu_ctl_s ctl;
   ccu_res_s res;
   int err_total, checks, tests;
   ccu_unit i_dut (.clk_i(clk), .rst_i(rst), .start_i(start), .req_i(req), .ctl_i(ctl),
      .busy_o(busy), .done_o(done), .res_o(res), .rd_req_o(rd_req), .rd_addr1_o(a1),
      .rd_addr2_o(a2), .rd_valid_i(rd_valid), .rd_byte1_i(b1), .rd_byte2_i(b2));
   ccu_mem_model i_mem (.clk_i(clk), .slow_i(slow), .req_i(rd_req), .addr1_i(a1),
      .addr2_i(a2), .valid_o(rd_valid), .byte1_o(b1), .byte2_o(b2));
   ////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   // Checking and closing
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic cmp(input ccu_res_s e);
      chk(64'({res.cc & ~{3{e.cc_undef}}, res.cc_undef, res.dst_we, res.invalid_op,
         res.reserved_enc, res.fault}), 64'({e.cc & ~{3{e.cc_undef}}, e.cc_undef,
         e.dst_we, e.invalid_op, e.reserved_enc, e.fault}));
      if (e.dst_we) chk(64'(res.dst), 64'(e.dst));
   endtask : cmp
   // One operation, bounded wait for completion
   task automatic run(input logic [11:0] op, input logic [63:0] s1, s2, input logic [31:0] n);
      int w;
      @(negedge clk);
      req = {op, s1, s2, n};
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      if (op == CCU_OP_CMPSTR && n != 32'h0) chk(64'(busy), 64'h1);
      w = 0;
      while (done !== 1'b1 && w < 4000) begin
         @(negedge clk);
         w++;
      end
      if (w == 4000) begin
         err_total++;
         report_and_stop();
      end
      chk(64'(busy), 64'h0);
      tests++;
      $display("test %0d done", tests);
   endtask : run
   ////////////////////////////////////////////////////////////////
   // Expected results
   function automatic ccu_res_s exp_int(logic [11:0] op, logic [31:0] a, b);
      ccu_res_s e;
      logic lt;
      e = '0;
      lt = op[0] ? ($signed(a) < $signed(b)) : (a < b);
      e.cc = lt ? CCU_CC_LESS : (a == b) ? CCU_CC_EQUAL : CCU_CC_GREATER;
      e.dst_we = 1'b1;
      e.dst = op[1] ? b - 32'h1 : b + 32'h1;
      return e;
   endfunction : exp_int
   // Class bits: nan, snan, denormal, sign, magnitude
   function automatic logic [67:0] fx(logic l, logic [63:0] v);
      logic e1, e0, mz, q;
      e1 = l ? &v[62:52] : &v[30:23];
      e0 = l ? ~|v[62:52] : ~|v[30:23];
      mz = l ? |v[51:0] : |v[22:0];
      q = l ? v[51] : v[22];
      return {e1 & mz, e1 & mz & ~q, e0 & mz, l ? v[63] : v[31],
         l ? {1'b0, v[62:0]} : {33'h0, v[30:0]}};
   endfunction : fx
   function automatic ccu_res_s exp_real(logic [11:0] op, logic [63:0] a, b, ccu_ctl_s c);
      logic [67:0] fa, fb;
      logic signed [64:0] ka, kb;
      ccu_res_s e;
      fa = fx(op[4], a);
      fb = fx(op[4], b);
      ka = fa[64] ? -{1'b0, fa[63:0]} : {1'b0, fa[63:0]};
      kb = fb[64] ? -{1'b0, fb[63:0]} : {1'b0, fb[63:0]};
      e = '0;
      e.cc = (fa[67] | fb[67]) ? CCU_CC_UNORD : (ka < kb) ? CCU_CC_LESS :
         (ka == kb) ? CCU_CC_EQUAL : CCU_CC_GREATER;
      e.invalid_op = op[0] ? fa[66] | fb[66] : fa[67] | fb[67];
      e.reserved_enc = c.norm_mode & (fa[65] | fb[65]);
      e.cc_undef = e.reserved_enc;
      e.fault = (e.invalid_op & ~c.invalid_mask) | (e.reserved_enc & ~c.resenc_mask);
      return e;
   endfunction : exp_real
   // Operand of a class: normal, zero, quiet, signaling, denormal
   function automatic logic [63:0] mk(logic l, int c, logic [63:0] r);
      logic [127:0] m;
      case (c)
         0: m = l ? {64'h4000000000000000, 64'h0010000000000000} : {64'h40000000, 64'h00800000};
         1: m = l ? {64'h7FFFFFFFFFFFFFFF, 64'h0} : {64'h7FFFFFFF, 64'h0};
         2: m = l ? {64'h0, 64'h7FF8000000000000} : {64'h0, 64'h7FC00000};
         3: m = l ? {64'h0008000000000000, 64'h7FF0000000000001} : {64'h00400000, 64'h7F800001};
         default: m = l ? {64'h7FF0000000000000, 64'h1} : {64'h7F800000, 64'h1};
      endcase
      return ((l ? r : {32'h0, r[31:0]}) & ~m[127:64]) | m[63:0];
   endfunction : mk
   function automatic logic [2:0] exp_str(logic [7:0] s, logic [31:0] n);
      logic [31:0] i;
      for (i = 0; i < n; i++) begin
         if (i_mem.mem1[s + i[7:0]] != i_mem.mem2[s + i[7:0]]) begin
            return (i_mem.mem1[s + i[7:0]] > i_mem.mem2[s + i[7:0]]) ? CCU_CC_GREATER : CCU_CC_LESS;
         end
      end
      return CCU_CC_EQUAL;
   endfunction : exp_str
   ////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [11:0] op;
      logic [63:0] x, y;
      logic [31:0] n;
      int ca, cb;
      ccu_res_s e;
      start = 1'b0;
      req = '0;
      ctl = '0;
      slow = 1'b0;
      rst = 1'b1;
      err_total = 0;
      checks = 0;
      tests = 0;
      void'($urandom(92513));
      repeat (12) @(negedge clk);
      rst = 1'b0;
      // Integer and ordinal compare with step, corners mixed in
      for (int k = 0; k < 60; k++) begin
         op = 12'h5A4 + 12'($urandom % 4);
         y = {32'h0, $urandom};
         if (k % 3 == 0) y = {32'h0, k[1], {31{k[0]}}};
         x = (k % 5 == 0) ? y : {32'h0, $urandom};
         run(op, x, y, 32'h0);
         cmp(exp_int(op, x[31:0], y[31:0]));
      end
      // Real compares of every class, both widths
      for (int k = 0; k < 120; k++) begin
         op = 12'h684 | 12'($urandom % 2) | (12'($urandom % 2) << 4);
         ca = $urandom % 5;
         cb = $urandom % 5;
         ctl = ccu_ctl_s'(3'($urandom % 8));
         if (ca inside {2, 3} || cb inside {2, 3}) ctl.norm_mode = 1'b0;
         // Long operands arrive as one even register pair
         x = mk(op[4], ca, {$urandom, $urandom});
         y = (k % 4 == 0) ? x : mk(op[4], cb, {$urandom, $urandom});
         run(op, x, y, 32'h0);
         e = exp_real(op, x, y, ctl);
         cmp(e);
      end
      // String compares: empty, huge, random lengths and latency
      for (int k = 0; k < 14; k++) begin
         for (int j = 0; j < 256; j++) begin
            i_mem.mem1[j] = ($urandom % 2) ? 8'h80 : 8'h7F;
            i_mem.mem2[j] = ($urandom % 16) ? i_mem.mem1[j] : ~i_mem.mem1[j];
         end
         x = {32'h0, $urandom};
         i_mem.mem2[x[7:0] + 8'h2] = ~i_mem.mem1[x[7:0] + 8'h2];
         n = (k == 0) ? 32'h0 : (k == 1) ? 32'hFFFFFFFF : 32'($urandom % 12 + 1);
         slow = 1'($urandom % 2);
         run(CCU_OP_CMPSTR, x, x + 64'h100, n);
         chk(64'(res.cc), 64'(exp_str(x[7:0], n)));
      end
      // Opcode outside the unit gives equal with no write
      run(12'h000, 64'h1, 64'h2, 32'h0);
      e = '0;
      e.cc = CCU_CC_EQUAL;
      cmp(e);
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
